// [hdl/mcfc_codec.sv]
// command frame receiver, checker and reply framer
// Summary of operation
// - serial frame: address, cmd, type, motor, value, sum
// - command sum is 8-bit wrap of prior bytes
// - CAN command: seven core bytes, no address/sum
// - reply: raddr, maddr, status, cmd, value, sum
// - reply sum is 8-bit wrap of prior bytes
// - CAN reply: no address/sum, id is raddr
// - reply after command processing completes, or at once on a sum error
// - stay receiving; transmit only for replies
// - never transmit without a received command
// - status 100 on success
// - status 101 when stored to program memory
// - status 1 sum, 2 cmd, 3 type, 4 value
// - status 5 locked, 6 not available
module mcfc_codec #(
    parameter int unsigned FRAME_GAP_CYCLES = mcfc_pkg::FRAME_GAP_CYCLES
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // configuration pins
    input  wire logic                can_mode_pin,
    input  wire logic [7:0]          module_address_pin,
    input  wire logic [7:0]          reply_address_pin,
    // received bytes from the link
    input  wire logic                rx_valid,
    input  wire logic                rx_first,
    input  wire logic [7:0]          rx_data,
    // reply bytes to the link
    output logic                     tx_valid,
    output logic [7:0]               tx_data,
    output logic                     tx_last,
    input  wire logic                tx_ready,
    output logic                     tx_enable,
    output logic [7:0]               tx_can_id,
    // command executor
    output logic                     cmd_valid,
    output mcfc_pkg::mcfc_cmd_t      cmd,
    input  wire logic                cmd_ready,
    input  wire logic                res_valid,
    input  wire mcfc_pkg::mcfc_res_t res,
    // frame event
    output logic                     frame_dropped
);
    import mcfc_pkg::*;

    localparam int unsigned GAP_W = $clog2(FRAME_GAP_CYCLES + 1);
    localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(FRAME_GAP_CYCLES);

    mcfc_state_t      state;
    mcfc_state_t      next_state;
    logic [GAP_W-1:0] gap_cnt;
    logic [3:0]       rx_idx;
    logic [3:0]       tx_idx;
    logic [7:0]       rx_addr;
    logic [7:0]       rx_sum;
    logic [7:0]       tx_sum;
    logic [7:0]       reply_addr;
    logic [7:0]       reply_status;
    logic [31:0]      reply_value;
    logic             can_mode;
    logic [7:0]       module_address;
    logic [7:0]       reply_address_sync;

    // pin levels enter the clock domain through two flops
    mcfc_sync #(
        .WIDTH (17)
    ) u_sync (
        .clock  (clock),
        .resetn (resetn),
        .d      ({can_mode_pin, module_address_pin, reply_address_pin}),
        .q      ({can_mode, module_address, reply_address_sync})
    );

    // frame geometry for the current link type
    wire [3:0] first_idx = can_mode ? CM_CMD : CM_ADDR;
    wire [3:0] rx_last_idx = can_mode ? CM_VAL_LSB : CM_SUM;
    wire [3:0] tx_first_idx = can_mode ? RP_MADDR : RP_RADDR;
    wire [3:0] tx_last_idx = can_mode ? RP_VAL_B0 : RP_SUM;

    // receive byte decode; bytes are ignored outside the receive state
    wire       receiving = state == S_RECEIVE;
    wire       rx_fire = rx_valid && receiving;
    wire       rx_stale = gap_cnt == GAP_LIMIT;
    wire       rx_restart = rx_first || rx_stale || rx_idx < first_idx;
    wire [3:0] byte_idx = rx_restart ? first_idx : rx_idx;
    wire       rx_at_start = rx_fire && byte_idx == first_idx;
    wire       rx_body = rx_fire && byte_idx != CM_SUM;
    wire       rx_done = rx_fire && byte_idx == rx_last_idx;

    // end-of-frame verdicts on a byte-serial link
    wire       addr_miss = !can_mode && rx_addr != module_address;
    wire       sum_bad = !can_mode && rx_sum != rx_data;
    wire       frame_drop = rx_done && addr_miss;
    wire       frame_bad = rx_done && !addr_miss && sum_bad;
    wire       frame_good = rx_done && !addr_miss && !sum_bad;

    // handshakes with executor and link
    wire       issue_fire = state == S_ISSUE && cmd_ready;
    wire       result_fire = state == S_WAIT && res_valid;
    wire       tx_fire = tx_valid && tx_ready;
    wire       tx_end = tx_fire && tx_last;
    wire       tx_start = result_fire || frame_bad;
    wire [7:0] reply_sum = tx_sum + tx_data;

    // link and executor handshake outputs
    assign tx_valid = state == S_REPLY;
    assign tx_enable = state == S_REPLY;
    assign tx_last = tx_idx == tx_last_idx;
    assign tx_can_id = reply_addr;
    assign cmd_valid = state == S_ISSUE;

    // executor outcome to status code
    function automatic logic [7:0] status_of(input mcfc_outcome_t outcome);
        logic [7:0] code;
        code = ST_UNAVAIL;
        unique case (outcome)
            OUT_OK:        code = ST_OK;
            OUT_STORED:    code = ST_STORED;
            OUT_BAD_CMD:   code = ST_BAD_CMD;
            OUT_BAD_TYPE:  code = ST_BAD_TYPE;
            OUT_BAD_VALUE: code = ST_BAD_VALUE;
            OUT_LOCKED:    code = ST_LOCKED;
            OUT_UNAVAIL:   code = ST_UNAVAIL;
        endcase
        return code;
    endfunction

    // reply byte at a given position, most significant value byte first
    function automatic logic [7:0] reply_byte(input logic [3:0] idx);
        logic [7:0] b;
        b = reply_sum;
        case (idx)
            RP_RADDR:  b = reply_address_sync; // first byte loads before reply_addr settles
            RP_MADDR:  b = module_address;
            RP_STATUS: b = reply_status;
            RP_CMD:    b = cmd.command;
            RP_VAL_B3: b = reply_value[31:24];
            RP_VAL_B2: b = reply_value[23:16];
            RP_VAL_B1: b = reply_value[15:8];
            RP_VAL_B0: b = reply_value[7:0];
            default:   b = reply_sum;
        endcase
        return b;
    endfunction

    wire [7:0] first_reply_byte = reply_byte(tx_first_idx);
    wire [7:0] next_reply_byte = reply_byte(tx_idx + 4'h1);

    // next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            S_RECEIVE:
            begin
                if (frame_bad)
                    next_state = S_REPLY;
                else if (frame_good)
                    next_state = S_ISSUE;
            end
            S_ISSUE:
            begin
                if (cmd_ready)
                    next_state = S_WAIT;
            end
            S_WAIT:
            begin
                if (res_valid)
                    next_state = S_REPLY;
            end
            S_REPLY:
            begin
                if (tx_end)
                    next_state = S_RECEIVE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            state <= S_RECEIVE;
        else
            state <= next_state;
    end

    // inter-byte gap counter, saturating at the limit
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            gap_cnt <= '0;
        else if (rx_fire)
            gap_cnt <= '0;
        else if (!rx_stale)
            gap_cnt <= gap_cnt + GAP_W'(1);
    end

    // receive position, back to the frame start after the last byte
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rx_idx <= CM_ADDR;
        else if (rx_done)
            rx_idx <= first_idx;
        else if (rx_fire)
            rx_idx <= byte_idx + 4'h1;
    end

    // field capture from the byte stream
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_addr <= 8'h00;
            cmd     <= '0;
        end
        else if (rx_fire)
        begin
            if (byte_idx == CM_ADDR)
                rx_addr <= rx_data;
            if (byte_idx == CM_CMD)
                cmd.command <= rx_data;
            if (byte_idx == CM_TYPE)
                cmd.kind <= rx_data;
            if (byte_idx == CM_MOTOR)
                cmd.motor <= rx_data;
            if (byte_idx >= CM_VAL_MSB && byte_idx <= CM_VAL_LSB)
                cmd.value <= {cmd.value[23:0], rx_data};
        end
    end

    // command checksum over every byte before the checksum byte
    mcfc_sum u_rx_sum (
        .clock  (clock),
        .resetn (resetn),
        .clear  (rx_at_start),
        .add    (rx_body),
        .data   (rx_data),
        .sum    (rx_sum)
    );

    // reply checksum over every byte already sent
    mcfc_sum u_tx_sum (
        .clock  (clock),
        .resetn (resetn),
        .clear  (tx_start),
        .add    (tx_fire),
        .data   (tx_data),
        .sum    (tx_sum)
    );

    // reply contents, fixed once the command has been judged
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            reply_addr   <= 8'h00;
            reply_status <= ST_OK;
            reply_value  <= 32'h0000_0000;
        end
        else if (frame_bad)
        begin
            reply_addr   <= reply_address_sync;
            reply_status <= ST_BAD_SUM;
            reply_value  <= ERR_VALUE;
        end
        else if (result_fire)
        begin
            reply_addr   <= reply_address_sync;
            reply_status <= status_of(res.outcome);
            reply_value  <= res.value;
        end
    end

    // reply position register; held at the first position outside the reply state
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            tx_idx <= RP_RADDR;
        else if (state != S_REPLY)
            tx_idx <= tx_first_idx;
        else if (tx_fire && !tx_last)
            tx_idx <= tx_idx + 4'h1;
    end

    // the outgoing byte follows the reply position
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            tx_data <= 8'h00;
        else if (state != S_REPLY)
            tx_data <= first_reply_byte;
        else if (tx_fire && !tx_last)
            tx_data <= next_reply_byte;
    end

    // pulse when a serial frame for another module is discarded
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            frame_dropped <= 1'b0;
        else
            frame_dropped <= frame_drop;
    end

endmodule

// [hdl/mcfc_pkg.sv]
// constants and carrier types of the motion command frame codec
package mcfc_pkg;

    // module clock
    localparam int unsigned CLOCK_HZ          = 25_000_000;

    // idle gap on a byte-serial link after which a new frame is assumed
    localparam int unsigned FRAME_GAP_US      = 5000;
    localparam int unsigned FRAME_GAP_CYCLES  = FRAME_GAP_US * (CLOCK_HZ / 1_000_000);

    // byte positions in a command frame
    localparam logic [3:0]  CM_ADDR           = 4'h0;
    localparam logic [3:0]  CM_CMD            = 4'h1;
    localparam logic [3:0]  CM_TYPE           = 4'h2;
    localparam logic [3:0]  CM_MOTOR          = 4'h3;
    localparam logic [3:0]  CM_VAL_MSB        = 4'h4;
    localparam logic [3:0]  CM_VAL_LSB        = 4'h7;
    localparam logic [3:0]  CM_SUM            = 4'h8;

    // byte positions in a reply frame
    localparam logic [3:0]  RP_RADDR          = 4'h0;
    localparam logic [3:0]  RP_MADDR          = 4'h1;
    localparam logic [3:0]  RP_STATUS         = 4'h2;
    localparam logic [3:0]  RP_CMD            = 4'h3;
    localparam logic [3:0]  RP_VAL_B3         = 4'h4;
    localparam logic [3:0]  RP_VAL_B2         = 4'h5;
    localparam logic [3:0]  RP_VAL_B1         = 4'h6;
    localparam logic [3:0]  RP_VAL_B0         = 4'h7;
    localparam logic [3:0]  RP_SUM            = 4'h8;

    // reply status codes
    localparam logic [7:0]  ST_OK             = 8'h64;
    localparam logic [7:0]  ST_STORED         = 8'h65;
    localparam logic [7:0]  ST_BAD_SUM        = 8'h01;
    localparam logic [7:0]  ST_BAD_CMD        = 8'h02;
    localparam logic [7:0]  ST_BAD_TYPE       = 8'h03;
    localparam logic [7:0]  ST_BAD_VALUE      = 8'h04;
    localparam logic [7:0]  ST_LOCKED         = 8'h05;
    localparam logic [7:0]  ST_UNAVAIL        = 8'h06;

    // value reported with a checksum error
    localparam logic [31:0] ERR_VALUE         = 32'h0000_0000;

    // outcome of a command as judged by the executor
    typedef enum logic [2:0] {
        OUT_OK,
        OUT_STORED,
        OUT_BAD_CMD,
        OUT_BAD_TYPE,
        OUT_BAD_VALUE,
        OUT_LOCKED,
        OUT_UNAVAIL
    } mcfc_outcome_t;

    // decoded command handed to the executor
    typedef struct packed {
        logic [7:0]  command;
        logic [7:0]  kind;
        logic [7:0]  motor;
        logic [31:0] value;
    } mcfc_cmd_t;

    // result returned by the executor
    typedef struct packed {
        mcfc_outcome_t outcome;
        logic [31:0]   value;
    } mcfc_res_t;

    // codec states
    typedef enum logic [1:0] {
        S_RECEIVE,
        S_ISSUE,
        S_WAIT,
        S_REPLY
    } mcfc_state_t;

endpackage

// [hdl/mcfc_sum.sv]
// 8-bit wrapping checksum accumulator
module mcfc_sum (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       resetn,
    // control
    input  wire logic       clear,
    input  wire logic       add,
    input  wire logic [7:0] data,
    // running sum
    output logic      [7:0] sum
);

    // clear restarts the sum, clear with add starts it at data
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            sum <= 8'h00;
        else if (clear)
            sum <= add ? data : 8'h00;
        else if (add)
            sum <= sum + data; // wraps at 8 bits
    end

endmodule

// [hdl/mcfc_sync.sv]
// two-stage synchroniser for pin levels
module mcfc_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             resetn,
    // pin side and synchronised side
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q    <= '0;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// [verif/mcfc_codec_properties.sv]
// port assertions for the frame codec
module mcfc_codec_props (
    // clock and reset
    input wire logic                clock,
    input wire logic                resetn,
    // link side
    input wire logic                can_mode_pin,
    input wire logic                rx_valid,
    input wire logic                tx_valid,
    input wire logic [7:0]          tx_data,
    input wire logic                tx_last,
    input wire logic                tx_ready,
    input wire logic                tx_enable,
    // executor side
    input wire logic                cmd_valid,
    input wire mcfc_pkg::mcfc_cmd_t cmd,
    input wire logic                cmd_ready,
    input wire logic                res_valid,
    input wire logic                frame_dropped
);
    import mcfc_pkg::*;
    logic [7:0] acc;
    logic [3:0] idx;
    // accepted byte and status position
    wire        fire = tx_valid && tx_ready;
    wire  [3:0] pos  = can_mode_pin ? 4'h1 : 4'h2;
    // running sum and index of reply bytes
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            acc <= 8'h00;
            idx <= 4'h0;
        end
        else if (!tx_enable)
        begin
            acc <= 8'h00;
            idx <= 4'h0;
        end
        else if (fire)
        begin
            acc <= acc + tx_data;
            idx <= idx + 4'h1;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("reply byte moved");
    property p_cause;
        $rose(tx_enable) |-> $past(res_valid) || $past(rx_valid);
    endproperty
    a_cause: assert property (p_cause) else $error("unprompted send");
    property p_order;
        cmd_valid |-> !tx_enable;
    endproperty
    a_order: assert property (p_order) else $error("reply before result");
    property p_cmd;
        cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command not held");
    property p_end;
        fire && tx_last |=> !tx_valid && !tx_enable;
    endproperty
    a_end: assert property (p_end) else $error("bus kept after reply");
    property p_drop;
        frame_dropped |=> !frame_dropped && !tx_enable;
    endproperty
    a_drop: assert property (p_drop) else $error("foreign frame answered");
    property p_sum;
        fire && tx_last && !can_mode_pin |-> tx_data == acc;
    endproperty
    a_sum: assert property (p_sum) else $error("bad reply sum");
    property p_len;
        fire && tx_last |-> idx == (can_mode_pin ? 4'h6 : 4'h8);
    endproperty
    a_len: assert property (p_len) else $error("bad reply length");
    property p_code;
        fire && idx == pos |-> tx_data inside {8'h64, 8'h65, [8'h01:8'h06]};
    endproperty
    a_code: assert property (p_code) else $error("bad status code");
endmodule

bind mcfc_codec mcfc_codec_props i_mcfc_codec_props (
    .clock(clock), .resetn(resetn), .can_mode_pin(can_mode_pin), .rx_valid(rx_valid),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_enable(tx_enable), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .res_valid(res_valid), .frame_dropped(frame_dropped)
);

// [verif/mcfc_host.sv]
// host model: sends command frames and takes replies
module mcfc_host (
    // clock
    input wire logic       clock,
    // command bytes to the codec
    output logic           rx_valid,
    output logic           rx_first,
    output logic [7:0]     rx_data,
    // reply bytes from the codec
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    output logic           tx_ready,
    // drop tx_ready on every other cycle
    input wire logic       slow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] q[$];
    logic       busy;
    // idle link at start
    initial
    begin
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data  = 8'h00;
        tx_ready = 1'b1;
        busy     = 1'b0;
    end
    // accept reply bytes, stalling when slow
    always @(negedge clock)
        tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clock)
        if (tx_valid && tx_ready)
        begin
            q.push_back(tx_data);
            if (tx_last)
                busy <= 1'b0;
        end
    // one command; serial frames carry address and sum
    task automatic send(input logic can, input logic [7:0] a, c, t, m, input logic [31:0] v,
                        input logic [7:0] err, input logic reply);
        logic [7:0] b[$];
        int         w;
        b = {c, t, m, v[31:24], v[23:16], v[15:8], v[7:0]};
        w = 0;
        if (!can)
        begin
            b.push_front(a);
            b.push_back(b.sum() + err);
        end
        while (busy && w < 500)
        begin
            @(negedge clock);
            w++;
        end
        foreach (b[i])
        begin
            @(negedge clock);
            rx_valid = 1'b1;
            rx_first = (i == 0);
            rx_data  = b[i];
        end
        @(negedge clock);
        rx_valid = 1'b0;
        rx_first = 1'b0;
        rx_data  = ~rx_data; // no stale byte on a released line
        busy     = reply;
    endtask
endmodule

// [verif/test_mcfc_codec.sv]
// self-checking bench for the frame codec
module test_mcfc_codec;
    timeunit 1ns;
    timeprecision 1ns;
    import mcfc_pkg::*;
    localparam logic [7:0] MADDR = 8'h2A;
    localparam logic [7:0] RADDR = 8'h03;
    logic       clock;
    logic       resetn;
    logic       can_mode_pin;
    logic       rx_valid;
    logic       rx_first;
    logic [7:0] rx_data;
    logic       tx_valid;
    logic [7:0] tx_data;
    logic       tx_last;
    logic       tx_ready;
    logic       tx_enable;
    logic [7:0] tx_can_id;
    logic       cmd_valid;
    mcfc_cmd_t  cmd;
    logic       cmd_ready;
    logic       res_valid;
    mcfc_res_t  res;
    logic       frame_dropped;
    logic       slow;
    int         n_mismatch;
    int         comparisons;
    mcfc_codec #(.FRAME_GAP_CYCLES(20)) i_mcfc_codec (
        .clock(clock), .resetn(resetn), .can_mode_pin(can_mode_pin),
        .module_address_pin(MADDR), .reply_address_pin(RADDR),
        .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .tx_enable(tx_enable), .tx_can_id(tx_can_id), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .res_valid(res_valid), .res(res), .frame_dropped(frame_dropped)
    );
    mcfc_host i_mcfc_host (
        .clock(clock), .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow)
    );
    // 25 MHz clock
    always #20 clock = ~clock;
    // compare one result
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // counts and verdict
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // executor: take the command, answer after dly cycles
    task automatic serve(input mcfc_cmd_t e, input mcfc_outcome_t o, input logic [31:0] v, input int dly);
        int w;
        w = 0;
        while (cmd_valid !== 1'b1 && w < 100)
        begin
            @(negedge clock);
            w++;
        end
        chk(cmd, e);
        // odd delays keep the command waiting one cycle
        repeat (dly % 2) @(negedge clock);
        chk(cmd_valid, 1'b1);
        cmd_ready = 1'b1;
        @(negedge clock);
        cmd_ready = 1'b0;
        repeat (dly)
        begin
            @(negedge clock);
            chk(tx_enable, 1'b0);
        end
        res       = '{o, v};
        res_valid = 1'b1;
        @(negedge clock);
        res_valid = 1'b0;
    endtask
    // compare the reply bytes the host collected
    task automatic reply(input logic can, input logic [7:0] st, c, input logic [31:0] v);
        logic [7:0] e[$];
        int         w;
        e = {MADDR, st, c, v[31:24], v[23:16], v[15:8], v[7:0]};
        w = 0;
        if (!can)
        begin
            e.push_front(RADDR);
            e.push_back(e.sum());
        end
        while (i_mcfc_host.q.size() < e.size() && w < 300)
        begin
            @(negedge clock);
            w++;
        end
        repeat (4) @(negedge clock);
        chk(i_mcfc_host.q.size(), e.size());
        foreach (e[i])
            chk(i_mcfc_host.q[i], e[i]);
        if (can)
            chk(tx_can_id, RADDR);
        chk(tx_enable, 1'b0);
        i_mcfc_host.q.delete();
    endtask
    // one command through host, codec and executor
    task automatic round(input logic can, input mcfc_cmd_t e, input mcfc_outcome_t o,
                         input logic [31:0] v, input int dly, input logic [7:0] st);
        fork
            i_mcfc_host.send(can, MADDR, e.command, e.kind, e.motor, e.value, 8'h00, 1'b1);
            serve(e, o, v, dly);
        join
        reply(can, st, e.command, v);
    endtask
    // every outcome maps to its status code, back to back
    task automatic t_outcomes();
        logic [7:0] code[7] = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
        for (int i = 0; i < 7; i++)
        begin
            slow = i[0];
            round(1'b0, '{8'h05 + i[7:0], 8'h80, 8'hFF, 32'h8000_00FF ^ i}, mcfc_outcome_t'(i),
                  32'hDEAD_BEEF - i, i, code[i]);
        end
        slow = 1'b0;
    endtask
    // corrupted sum: status 1, value 0, no command issued
    task automatic t_badsum();
        i_mcfc_host.send(1'b0, MADDR, 8'h06, 8'h01, 8'h00, 32'h1234_5678, 8'h01, 1'b1);
        chk(cmd_valid, 1'b0);
        reply(1'b0, 8'h01, 8'h06, 32'h0000_0000);
    endtask
    // frame for another module: dropped, never answered
    task automatic t_foreign();
        int w;
        w = 0;
        i_mcfc_host.send(1'b0, MADDR + 8'h01, 8'h06, 8'h01, 8'h00, 32'h0000_0001, 8'h00, 1'b0);
        while (frame_dropped !== 1'b1 && w < 5)
        begin
            @(negedge clock);
            w++;
        end
        chk(frame_dropped, 1'b1);
        repeat (40) @(negedge clock);
        chk(i_mcfc_host.q.size(), 0);
        chk(cmd_valid, 1'b0);
    endtask
    // CAN framing: seven bytes each way, id carries reply address
    task automatic t_can();
        can_mode_pin = 1'b1;
        repeat (4) @(negedge clock);
        round(1'b1, '{8'h0A, 8'h02, 8'h01, 32'hFFFF_FF80}, OUT_OK, 32'h0102_0304, 2, 8'h64);
        can_mode_pin = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    // watchdog: the run needs some 350 cycles, allow 25000
    initial
    begin
        #1_000_000;
        n_mismatch++;
        conclude();
    end
    // reset, then the scenarios
    initial
    begin
        clock        = 1'b0;
        resetn       = 1'b0;
        can_mode_pin = 1'b0;
        cmd_ready    = 1'b0;
        res_valid    = 1'b0;
        res          = '0;
        slow         = 1'b0;
        n_mismatch   = 0;
        comparisons  = 0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        chk(tx_enable, 1'b0);
        t_outcomes();
        t_badsum();
        t_foreign();
        t_can();
        conclude();
    end
endmodule
